// ---- common/flash_pkg.sv ----
// Shared constants, carriers and states for the serial flash command front end
// ----------------------------------------------------------------------------
// Functional notes
// - Start in clock mode 3 after reset
// - Data output undriven until response phase
// - Frames start only on select falling edge
// - Each select fall outside power-on reset samples clock idle level
// - Power-on reset blocks every command
// - Enter standby once power-up completes
// - Program or erase held until delay
// - Reserved bit, 13 page, 10 byte bits
// - Page read: both addresses, four dummies
// - Buffer reads: byte address, 0/1 dummies
// ----------------------------------------------------------------------------
package flash_pkg;

    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam int CLK_MHZ                   = 250;     // Core clock rate
    localparam int SUPPLY_TO_SELECT_WAIT_US  = 105;     // Host side wait
    localparam int SUPPLY_TO_SELECT_WAIT_CYC = SUPPLY_TO_SELECT_WAIT_US * CLK_MHZ;
    localparam int POWER_UP_WRITE_DELAY_MS   = 3;       // Longest internal delay
    localparam int POWER_UP_WRITE_DELAY_CYC  = POWER_UP_WRITE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int PW_CNT_W                  = 20;      // Holds the delay count

    // ------------------------------------------------------------------------
    // Opcodes with their own framing
    // ------------------------------------------------------------------------
    localparam logic [7:0] OP_BUF1_READ_SLOW = 8'hD1;   // No dummy
    localparam logic [7:0] OP_PAGE_READ      = 8'hD2;   // Four dummies
    localparam logic [7:0] OP_BUF2_READ_SLOW = 8'hD3;   // No dummy
    localparam logic [7:0] OP_BUF1_READ      = 8'hD4;   // One dummy
    localparam logic [7:0] OP_BUF2_READ      = 8'hD6;   // One dummy
    localparam logic [7:0] OP_STATUS         = 8'hD7;   // No address at all

    // ------------------------------------------------------------------------
    // Bit counts (counted down to zero) and address layout
    // ------------------------------------------------------------------------
    localparam logic [4:0] OP_BITS_LAST         = 5'h07;  // 8 opcode bits
    localparam logic [4:0] ADDR_BITS_LAST       = 5'h17;  // 24 address bits
    localparam logic [4:0] DUMMY_PAGE_READ_LAST = 5'h1F;  // 4 dummy bytes
    localparam logic [4:0] DUMMY_BUF_READ_LAST  = 5'h07;  // 1 dummy byte
    localparam int PAGE_ADDR_MSB = 22;                    // Bit 23 is reserved
    localparam int PAGE_ADDR_LSB = 10;
    localparam int BYTE_ADDR_MSB = 9;
    localparam logic MODE3_RESET = 1'b1;                  // Clock mode after reset

    // ------------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  opcode;      // Command byte
        logic [12:0] page_addr;   // Zero when the opcode ignores it
        logic [9:0]  byte_addr;   // Byte within page or buffer
    } cmd_t;

    typedef struct packed {
        logic sck;                // Serial clock
        logic cs_n;               // Chip select, active low
        logic si;                 // Serial data in
        logic por;                // Power-on reset, active high
    } pins_t;

    typedef enum {ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_OUT, ST_SINK} frame_st_t;

    // Opcodes that program or erase the array
    function automatic logic is_prog_erase(input logic [7:0] op);
        case (op)
            8'h50, 8'h58, 8'h59, 8'h7C, 8'h81, 8'h82,
            8'h83, 8'h85, 8'h86, 8'h88, 8'h89: is_prog_erase = 1'b1;
            default:                           is_prog_erase = 1'b0;
        endcase
    endfunction : is_prog_erase

endpackage : flash_pkg

// ---- verilog/pin_sync.sv ----
// Two-stage synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 4                   // Number of pins
) (
    input  wire logic         i_clk,      // Core clock
    input  wire logic         i_rst,      // Synchronous reset
    input  wire logic [W-1:0] i_d,        // Raw pins
    output logic      [W-1:0] o_lvl,      // Synchronised level
    output logic      [W-1:0] o_rise,     // One-cycle rise pulse
    output logic      [W-1:0] o_fall      // One-cycle fall pulse
);
    // ------------------------------------------------------------------------
    // Per-pin stages
    // ------------------------------------------------------------------------
    // First stage feeds only the second; edges compare second and third
    // Fill tracker: edges stay quiet until all three stages hold pin
    // values, so a pin already low at reset release gives no false fall
    logic [2:0] fill_r;                   // Stages loaded since reset
    wire        primed = fill_r[2];       // Edge outputs trustworthy

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fill_r <= 3'h0;
        end else begin
            fill_r <= {fill_r[1:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            logic meta_r;                 // First stage, metastable
            logic sync_r;                 // Second stage, safe
            logic prev_r;                 // Delayed copy for edges
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    prev_r <= 1'b1;
                end else begin
                    meta_r <= i_d[g];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign o_lvl[g]  = sync_r;
            assign o_rise[g] = primed & sync_r & ~prev_r;
            assign o_fall[g] = primed & ~sync_r & prev_r;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// ---- verilog/flash_front.sv ----
// Serial command front end: power-up state, clock mode and command framing
`timescale 1ns/1ns
`default_nettype none
module flash_front import flash_pkg::*; #(
    parameter int unsigned PW_CYC = POWER_UP_WRITE_DELAY_CYC  // Program/erase hold
) (
    input  wire logic       i_clk,        // Core clock, 250 MHz
    input  wire logic       i_rst,        // Synchronous reset, active high
    input  wire logic       i_sck,        // Serial clock pin
    input  wire logic       i_cs_n,       // Chip select pin, active low
    input  wire logic       i_si,         // Serial data in pin
    input  wire logic       i_por,        // Power-on reset, active high
    input  wire logic [7:0] i_rsp_data,   // Response byte from the core
    output logic            o_so,         // Serial data out
    output logic            o_so_oe,      // High while driving data out
    output logic            o_mode3,      // Clock mode 3 selected
    output logic            o_standby,    // Powered and awaiting command
    output logic            o_cmd_valid,  // One-cycle command pulse
    output cmd_t            o_cmd,        // Decoded command
    output logic            o_rsp_take    // Response byte consumed
);
    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    pins_t pin_raw;                       // Raw pins grouped
    pins_t pin_lvl;                       // Synchronised levels
    pins_t pin_rise;                      // Rising edges
    pins_t pin_fall;                      // Falling edges

    assign pin_raw = {i_sck, i_cs_n, i_si, i_por};

    pin_sync #(.W(4)) u_sync (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_d    (pin_raw),
        .o_lvl  (pin_lvl),
        .o_rise (pin_rise),
        .o_fall (pin_fall)
    );

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    frame_st_t            st_r;           // Frame phase
    frame_st_t            st_nxt;         // Next frame phase
    logic [4:0]           bit_r;          // Bits left in phase
    logic [4:0]           bit_nxt;        // Next bit count
    logic [23:0]          sh_r;           // Incoming shift register
    logic [7:0]           op_r;           // Latched opcode
    logic                 pend_r;         // Command waiting for delay
    logic [PW_CNT_W-1:0]  pw_cnt_r;       // Power-up delay counter
    logic                 pw_done_r;      // Delay elapsed
    logic [7:0]           out_sh_r;       // Outgoing bits
    logic [2:0]           out_cnt_r;      // Bit within outgoing byte

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire        sck_q      = pin_lvl.sck;
    wire        si_q       = pin_lvl.si;
    wire        por_q      = pin_lvl.por;
    wire        sck_rise   = pin_rise.sck;
    wire        sck_fall   = pin_fall.sck;
    wire        cs_fall    = pin_fall.cs_n;
    wire        frame_live = !por_q && !pin_lvl.cs_n;
    wire        bit_zero   = (bit_r == 5'h00);
    wire [7:0]  op_full    = {sh_r[6:0], si_q};
    wire [23:0] addr_full  = {sh_r[22:0], si_q};
    wire [6:0]  sh_low     = sh_r[6:0];
    wire [12:0] page_in    = addr_full[PAGE_ADDR_MSB:PAGE_ADDR_LSB];
    wire        op_last    = frame_live && st_r == ST_OP && sck_rise && bit_zero;
    wire        addr_done  = frame_live && st_r == ST_ADDR && sck_rise && bit_zero;
    wire        op_status  = (op_full == OP_STATUS);
    wire        rd_slow    = (op_r == OP_BUF1_READ_SLOW) || (op_r == OP_BUF2_READ_SLOW);
    wire        rd_fast    = (op_r == OP_BUF1_READ) || (op_r == OP_BUF2_READ);
    wire        rd_page    = (op_r == OP_PAGE_READ);
    wire        cmd_fire   = (op_last && op_status) || addr_done;

    // Reserved bit never used; page bits dropped for buffer reads
    cmd_t new_cmd;
    assign new_cmd.opcode    = op_last ? op_full : op_r;
    assign new_cmd.page_addr = (op_last || rd_slow || rd_fast) ? 13'h0000 : page_in;
    assign new_cmd.byte_addr = op_last ? 10'h000 : addr_full[BYTE_ADDR_MSB:0];

    wire cmd_pe = is_prog_erase(new_cmd.opcode);

    // ------------------------------------------------------------------------
    // Next phase and bit count
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt  = st_r;
        bit_nxt = bit_r;
        if (por_q) begin
            st_nxt = ST_IDLE;
        end else if (pin_lvl.cs_n) begin
            st_nxt = ST_IDLE;
        end else if (cs_fall) begin
            st_nxt  = ST_OP;
            bit_nxt = OP_BITS_LAST;
        end else if (sck_rise) begin
            bit_nxt = bit_r - 5'h01;
            case (st_r)
                ST_OP: begin
                    if (bit_zero) begin
                        st_nxt  = op_status ? ST_OUT : ST_ADDR;
                        bit_nxt = ADDR_BITS_LAST;
                    end
                end
                ST_ADDR: begin
                    if (bit_zero && rd_page) begin
                        st_nxt  = ST_DUMMY;
                        bit_nxt = DUMMY_PAGE_READ_LAST;
                    end else if (bit_zero && rd_fast) begin
                        st_nxt  = ST_DUMMY;
                        bit_nxt = DUMMY_BUF_READ_LAST;
                    end else if (bit_zero) begin
                        st_nxt = rd_slow ? ST_OUT : ST_SINK;
                    end
                end
                ST_DUMMY: begin
                    // Dummy bit values are never looked at
                    if (bit_zero) begin
                        st_nxt = ST_OUT;
                    end
                end
                default: begin
                    bit_nxt = bit_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Frame registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r  <= ST_IDLE;
            bit_r <= 5'h00;
            sh_r  <= 24'h000000;
            op_r  <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            bit_r <= bit_nxt;
            if (frame_live && sck_rise && (st_r == ST_OP || st_r == ST_ADDR)) begin
                sh_r <= addr_full;
            end
            if (op_last) begin
                op_r <= op_full;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power-up delay and command issue
    // ------------------------------------------------------------------------
    // A second command arriving while one is held replaces it; the host
    // is expected to wait out the delay instead.
    always_ff @(posedge i_clk) begin
        if (i_rst || por_q) begin
            pw_cnt_r    <= '0;
            pw_done_r   <= 1'b0;
            pend_r      <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_cmd       <= '0;
        end else begin
            if (!pw_done_r) begin
                pw_cnt_r  <= pw_cnt_r + 1'b1;
                pw_done_r <= (pw_cnt_r == PW_CNT_W'(PW_CYC - 1));
            end
            if (cmd_fire) begin
                o_cmd       <= new_cmd;
                pend_r      <= cmd_pe && !pw_done_r;
                o_cmd_valid <= !(cmd_pe && !pw_done_r);
            end else if (pend_r && pw_done_r) begin
                pend_r      <= 1'b0;
                o_cmd_valid <= 1'b1;
            end else begin
                o_cmd_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode select, standby and data out
    // ------------------------------------------------------------------------
    // Output changes on falling clock in either mode, so the mode flag
    // only reports what was sampled.
    always_ff @(posedge i_clk) begin
        if (i_rst || por_q) begin
            o_mode3    <= MODE3_RESET;
            o_standby  <= 1'b0;
            o_so       <= 1'b0;
            o_so_oe    <= 1'b0;
            o_rsp_take <= 1'b0;
            out_sh_r   <= 8'h00;
            out_cnt_r  <= 3'h0;
        end else begin
            o_standby  <= (st_r == ST_IDLE);
            o_rsp_take <= 1'b0;
            if (cs_fall) begin
                o_mode3 <= sck_q;
            end
            if (st_nxt == ST_IDLE) begin
                o_so_oe   <= 1'b0;
                out_cnt_r <= 3'h0;
            end else if (st_r == ST_OUT && sck_fall) begin
                o_so_oe   <= 1'b1;
                out_cnt_r <= out_cnt_r + 3'h1;
                if (out_cnt_r == 3'h0) begin
                    o_so       <= i_rsp_data[7];
                    out_sh_r   <= {i_rsp_data[6:0], 1'b0};
                    o_rsp_take <= 1'b1;
                end else begin
                    o_so     <= out_sh_r[7];
                    out_sh_r <= {out_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_op_end;
        frame_live && st_r == ST_OP && sck_rise && bit_zero;
    endsequence
    sequence s_addr_end;
        frame_live && st_r == ST_ADDR && sck_rise && bit_zero;
    endsequence

    chk_reset_mode3: assert property ($fell(i_rst) |-> o_mode3)
        else $error("mode 3 not selected after reset");
    chk_so_released: assert property (st_r != ST_OUT |-> !o_so_oe)
        else $error("data out driven outside response");
    chk_frame_start: assert property (st_r == ST_IDLE && !cs_fall |=> st_r == ST_IDLE)
        else $error("frame began without select fall");
    chk_mode_sample: assert property (cs_fall && !por_q |=> o_mode3 == $past(sck_q))
        else $error("clock mode not sampled at select fall");
    chk_por_silent: assert property (por_q |=> st_r == ST_IDLE && !o_cmd_valid)
        else $error("activity during power-on reset");
    chk_standby_entry: assert property ($fell(por_q) |=> ##1 o_standby || st_r != ST_IDLE)
        else $error("standby not entered after power-up");
    chk_pw_gate: assert property (o_cmd_valid && is_prog_erase(o_cmd.opcode) |-> pw_done_r)
        else $error("program or erase issued before delay");
    chk_addr_split: assert property (s_addr_end ##0 (rd_page && !por_q)
        |=> o_cmd.page_addr == $past(page_in) && o_cmd.opcode == OP_PAGE_READ)
        else $error("page address field wrong");
    chk_page_dummy: assert property (s_addr_end ##0 rd_page
        |=> st_r == ST_DUMMY && bit_r == DUMMY_PAGE_READ_LAST)
        else $error("page read dummy count wrong");
    chk_buf_dummy: assert property (s_addr_end ##0 rd_fast
        |=> st_r == ST_DUMMY && bit_r == DUMMY_BUF_READ_LAST)
        else $error("buffer read dummy count wrong");
    chk_slow_direct: assert property (s_addr_end ##0 rd_slow
        |=> st_r == ST_OUT && o_cmd.page_addr == 13'h0000)
        else $error("slow buffer read framing wrong");
    chk_status_direct: assert property (s_op_end ##0 op_status
        |=> st_r == ST_OUT && o_cmd_valid)
        else $error("status opcode not answered at once");
    chk_msb_first: assert property (frame_live && st_r == ST_OP && sck_rise
        |=> sh_r[7:0] == {$past(sh_low), $past(si_q)})
        else $error("opcode not shifted msb first");

endmodule : flash_front
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// Behavioural serial host that frames commands for the flash front end
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input  wire logic i_clk,    // Core clock, pacing only
    input  wire logic i_so,     // Device data out
    input  wire logic i_so_oe,  // Device drives data out
    output logic      o_sck,    // Serial clock
    output logic      o_cs_n,   // Chip select, active low
    output logic      o_si      // Serial data to device
);
    logic so_lvl;               // Undriven line reads back inverted
    assign so_lvl = i_so_oe ? i_so : ~i_so;
    initial begin
        o_sck = 1'b1;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Half an sck period, 16 ns, moved on falling core edges
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask : half
    // Supply settle wait before any select
    task automatic power_wait();
        repeat (26250) @(negedge i_clk);
    endtask : power_wait
    // Idle clock level picks the mode, then select falls
    task automatic open(input logic m3);
        o_sck = m3;
        half();
        o_cs_n = 1'b0;
        half();
    endtask : open
    // One byte each way, MSB first; read back at end of high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_sck = 1'b0;
            o_si = tx[i];
            half();
            o_sck = 1'b1;
            half();
            rx[i] = so_lvl;
        end
    endtask : xfer
    // Clock back to idle, release select and invert data line
    task automatic close(input logic m3);
        o_sck = m3;
        half();
        o_cs_n = 1'b1;
        o_si = ~o_si;
        half();
        half();
    endtask : close
endmodule : spi_host_model
`default_nettype wire

// ---- dv/tb_flash_front.sv ----
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ns
`default_nettype none
module tb_flash_front;
    import flash_pkg::*;
    localparam int PW = 2000;            // Shortened program/erase hold
    logic       i_clk = 1'b0;            // Core clock
    logic       i_rst = 1'b1;            // Reset
    logic       i_por = 1'b1;            // Power-on reset
    logic [7:0] i_rsp_data = 8'hA6;      // Response byte, not bit-symmetric
    logic       sck, cs_n, si, so, so_oe, mode3, standby, cmd_valid, rsp_take;
    cmd_t       cmd, last_cmd;           // Decoded command, last seen
    int         err_count = 0, check_count = 0, cmd_cnt = 0, take_cnt = 0;
    always #2 i_clk = ~i_clk;
    flash_front #(.PW_CYC(PW)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .i_por(i_por), .i_rsp_data(i_rsp_data),
        .o_so(so), .o_so_oe(so_oe), .o_mode3(mode3), .o_standby(standby),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_rsp_take(rsp_take));
    spi_host_model host (.i_clk(i_clk), .i_so(so), .i_so_oe(so_oe),
        .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    // Count command and response pulses
    always @(posedge i_clk) begin
        if (cmd_valid === 1'b1) begin
            cmd_cnt++;
            last_cmd = cmd;
        end
        if (rsp_take === 1'b1) take_cnt++;
    end
    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected bit at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_bit
    task automatic chk_num(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_num
    task automatic chk_cmd(input cmd_t g, input cmd_t e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected command at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_cmd
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic do_reset();
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask : do_reset
    // Opcode, address bytes, dummies, then response bytes; output idle before
    task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] ad,
                         input int na, input int nd, input int nr, output logic [7:0] rd);
        logic [7:0] x;
        host.open(m3);
        host.xfer(op, x);
        for (int i = na - 1; i >= 0; i--) host.xfer(ad[8*i +: 8], x);
        for (int i = 0; i < nd; i++) host.xfer(8'h5A, x);
        chk_bit(so_oe, 1'b0);
        for (int i = 0; i < nr; i++) host.xfer(8'hFF, rd);
        host.close(m3);
    endtask : frame
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_bit(mode3, 1'b1);
        chk_bit(so_oe, 1'b0);
        chk_bit(standby, 1'b1);
    endtask : t_reset
    task automatic t_por();
        logic [7:0] r;
        int c0 = cmd_cnt;
        i_por = 1'b1;
        repeat (6) @(negedge i_clk);
        chk_bit(standby, 1'b0);
        frame(1'b1, OP_STATUS, 24'h0, 0, 0, 1, r);
        chk_num(cmd_cnt, c0);
        i_por = 1'b0;
        repeat (6) @(negedge i_clk);
    endtask : t_por
    // Buffer reads, reserved and page bits set but ignored
    task automatic t_buf();
        logic [7:0] ops [4] = '{OP_BUF1_READ_SLOW, OP_BUF2_READ_SLOW, OP_BUF1_READ, OP_BUF2_READ};
        int dum [4] = '{0, 0, 1, 1};
        logic [7:0] r;
        for (int k = 0; k < 4; k++) begin
            frame(1'b1, ops[k], 24'hFFFC00 | 24'(k * 37), 3, dum[k], 2, r);
            chk_cmd(last_cmd, {ops[k], 13'h0, 10'(k * 37)});
            chk_num(r, 8'hA6);
        end
    endtask : t_buf
    task automatic t_status();
        logic [7:0] r;
        int c0 = cmd_cnt, t0 = take_cnt;
        frame(1'b1, OP_STATUS, 24'h0, 0, 0, 2, r);
        chk_num(cmd_cnt, c0 + 1);
        chk_cmd(last_cmd, {OP_STATUS, 23'h0});
        chk_num(r, 8'hA6);
        chk_num(take_cnt, t0 + 2);
    endtask : t_status
    // Mode 0 page read with both addresses and four dummies
    task automatic t_page();
        logic [7:0] r;
        frame(1'b0, OP_PAGE_READ, 24'h9ABD5B, 3, 4, 1, r);
        chk_bit(mode3, 1'b0);
        chk_cmd(last_cmd, {OP_PAGE_READ, 13'h06AF, 10'h15B});
        chk_num(r, 8'hA6);
    endtask : t_page
    // Select already low when reset ends: frame ignored
    task automatic t_no_fall();
        logic [7:0] x;
        int c0 = cmd_cnt;
        host.o_cs_n = 1'b0;
        do_reset();
        chk_bit(mode3, 1'b1);
        host.xfer(OP_STATUS, x);
        host.xfer(8'hFF, x);
        chk_num(cmd_cnt, c0);
        chk_bit(so_oe, 1'b0);
        host.close(1'b1);
    endtask : t_no_fall
    // Program too soon after reset is held until the delay runs out
    task automatic t_hold();
        logic [7:0] r;
        int c0 = cmd_cnt;
        frame(1'b1, 8'h83, 24'h0ABC00, 3, 0, 0, r);
        chk_num(cmd_cnt, c0);
        for (int i = 0; i < PW + 200 && cmd_cnt == c0; i++) @(negedge i_clk);
        chk_num(cmd_cnt, c0 + 1);
        chk_cmd(last_cmd, {8'h83, 13'h02AF, 10'h000});
    endtask : t_hold
    initial begin
        repeat (80000) @(posedge i_clk);
        err_count++;
        stop_test();
    end
    initial begin
        do_reset();
        i_por = 1'b0;
        host.power_wait();
        t_reset();
        t_por();
        t_buf();
        t_status();
        t_page();
        t_no_fall();
        t_hold();
        stop_test();
    end
endmodule : tb_flash_front
`default_nettype wire
